// file: rtl/tko_touch_key_ctrl.sv
// What this block does
// - straps are sampled once after reset release and then held until the next reset
// - key states stay invalid for 350 ms of calibration after reset
// - full mode suppression straps pick off, off plus fast, two groups, or global
// - timeout straps pick 10 s, 60 s, infinite, or reserved
// - format and polarity straps pick binary or direct, polarity and drive
// - sync straps pick sync mode or low power at 110, 200, 360 ms
// - simplified mode is entered by the key6 sense to key7 option strap
// - in simplified mode one strap picks fast detect off-suppression or global suppression
// - simplified mode fixes direct push-pull high, 200 ms low power, 60 s timeout
// - direct mode drives one output per confirmed key, any number together
// - binary mode shows the reported key index on the three low outputs
// - binary mode keeps the first touched key until it releases
// - binary mode outputs are always push-pull active high
// - binary mode is never used in simplified mode
// - detect line is the or of all keys with the selected drive
// - each sync pulse fires burst a then burst b
// - sync mode free-runs after about 150 ms without pin change
// - low power is entered by a high pulse of at least 150 us
// - low power lasts until a touch, then full speed at 30 ms response
// - pin held high returns to low power when detection ends
// - pin held low keeps normal mode: 25 ms response from reset, 30 ms after a wake
// - binary mode forces the five upper outputs low
// - groups allow one key per group, global allows one key overall
// - fast detect confirms after 2, release needs 6 non-detections
// - stuck timeout runs per key and recalibrates that key only
`timescale 1ns/1ps
`default_nettype none
module tko_touch_key_ctrl #(
  parameter int MS_TICK_CYCLES  = tko_pkg::MS_TICK_CYCLES,
  parameter int LP_PULSE_CYCLES = tko_pkg::LP_PULSE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       suppress_strap_lo,
  input  wire logic       suppress_strap_hi,
  input  wire logic       stuck_timeout_strap_lo,
  input  wire logic       stuck_timeout_strap_hi,
  input  wire logic       output_format_strap,
  input  wire logic       output_polarity_strap,
  input  wire logic       sync_lowpower_strap_lo,
  input  wire logic       sync_lowpower_strap_hi,
  input  wire logic       simplified_mode_strap,
  input  wire logic       sync_or_lowpower_pin,
  input  wire logic [7:0] raw_detect,
  input  wire logic       raw_valid,
  output logic            burst_req,
  output logic            burst_group,
  output tko_pkg::tko_pins_t pins,
  output logic [7:0]      recal_req,
  output logic            calib_done,
  output logic            low_power_mode
);
  // key group: keys 0,1,4,5 share bit1 = 0
  function automatic logic key_group(input int k);
    key_group = k[1];
  endfunction

  // strap capture, one clock after reset release
  tko_pkg::tko_cfg_t cfg, next_cfg;
  logic              sampled, next_sampled;
  always_comb begin
    next_cfg     = cfg;
    next_sampled = 1'b1;
    if (!sampled) begin
      next_cfg.simplified = simplified_mode_strap;
      if (simplified_mode_strap) begin
        next_cfg.sup        = suppress_strap_lo ? tko_pkg::TKO_SUP_GLOBAL
                                                : tko_pkg::TKO_SUP_OFF;
        next_cfg.fast       = !suppress_strap_lo;
        next_cfg.timeout    = tko_pkg::TKO_TO_LONG;
        next_cfg.binary     = 1'b0;
        next_cfg.act_low    = 1'b0;
        next_cfg.open_drain = 1'b0;
        next_cfg.sync_mode  = 1'b0;
        next_cfg.lp_resp_ms = 9'(tko_pkg::LP_RESP_B_MS);
      end else begin
        case ({suppress_strap_hi, suppress_strap_lo})
          2'h0: begin next_cfg.sup = tko_pkg::TKO_SUP_OFF;    next_cfg.fast = 1'b0; end
          2'h1: begin next_cfg.sup = tko_pkg::TKO_SUP_OFF;    next_cfg.fast = 1'b1; end
          2'h2: begin next_cfg.sup = tko_pkg::TKO_SUP_GROUPS; next_cfg.fast = 1'b0; end
          default: begin next_cfg.sup = tko_pkg::TKO_SUP_GLOBAL; next_cfg.fast = 1'b0; end
        endcase
        next_cfg.timeout = tko_pkg::tko_timeout_t'({stuck_timeout_strap_hi,
                                                    stuck_timeout_strap_lo});
        next_cfg.binary     = !output_format_strap && !output_polarity_strap;
        next_cfg.act_low    = output_polarity_strap;
        next_cfg.open_drain = !output_format_strap && output_polarity_strap;
        next_cfg.sync_mode  = !sync_lowpower_strap_hi && !sync_lowpower_strap_lo;
        case ({sync_lowpower_strap_hi, sync_lowpower_strap_lo})
          2'h1:    next_cfg.lp_resp_ms = 9'(tko_pkg::LP_RESP_A_MS);
          2'h2:    next_cfg.lp_resp_ms = 9'(tko_pkg::LP_RESP_B_MS);
          default: next_cfg.lp_resp_ms = 9'(tko_pkg::LP_RESP_C_MS);
        endcase
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg     <= '0;
      sampled <= 1'b0;
    end else begin
      cfg     <= next_cfg;
      sampled <= next_sampled;
    end
  end

  // millisecond tick and startup timer
  logic [17:0] tick_cnt, next_tick_cnt;
  logic        ms_tick;
  logic [8:0]  init_ms, next_init_ms;
  logic        next_calib_done;
  assign ms_tick = (tick_cnt == 18'(MS_TICK_CYCLES - 1));
  always_comb begin
    next_tick_cnt   = ms_tick ? 18'h0_0000 : tick_cnt + 18'h0_0001;
    next_init_ms    = init_ms;
    next_calib_done = calib_done;
    if (ms_tick && !calib_done) begin
      next_init_ms = init_ms + 9'h001;
      if (init_ms == 9'(tko_pkg::STARTUP_MS - 1)) next_calib_done = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_cnt   <= '0;
      init_ms    <= '0;
      calib_done <= 1'b0;
    end else begin
      tick_cnt   <= next_tick_cnt;
      init_ms    <= next_init_ms;
      calib_done <= next_calib_done;
    end
  end

  // detection integrators, suppression and stuck-key timers
  logic [7:0]  active, next_active, next_recal;
  logic [2:0]  on_cnt  [8], next_on_cnt  [8];
  logic [2:0]  off_cnt [8], next_off_cnt [8];
  logic [15:0] stuck_ms[8], next_stuck_ms[8];
  always_comb begin
    logic [2:0]  thr;
    logic [15:0] limit;
    logic        busy;
    thr   = cfg.fast ? tko_pkg::DI_FAST : tko_pkg::DI_NORMAL;
    limit = (cfg.timeout == tko_pkg::TKO_TO_SHORT) ? 16'(tko_pkg::STUCK_SHORT_MS)
                                                   : 16'(tko_pkg::STUCK_LONG_MS);
    busy  = 1'b0;
    next_active = active;
    next_recal  = 8'h00;
    for (int k = 0; k < tko_pkg::NKEYS; k++) begin
      next_on_cnt[k]  = on_cnt[k];
      next_off_cnt[k] = off_cnt[k];
      next_stuck_ms[k] = active[k] ? stuck_ms[k] : 16'h0000;
    end
    for (int k = 0; k < tko_pkg::NKEYS; k++) begin
      // occupancy seen by key k, updated as lower keys confirm this cycle
      busy = 1'b0;
      for (int j = 0; j < tko_pkg::NKEYS; j++) begin
        if (j != k && next_active[j]) begin
          if (cfg.sup == tko_pkg::TKO_SUP_GLOBAL) busy = 1'b1;
          if (cfg.sup == tko_pkg::TKO_SUP_GROUPS && key_group(j) == key_group(k))
            busy = 1'b1;
        end
      end
      if (raw_valid && calib_done && key_group(k) == burst_group && burst_req) begin
        if (!active[k]) begin
          next_on_cnt[k] = raw_detect[k] ? on_cnt[k] + 3'h1 : 3'h0;
          if (raw_detect[k] && (on_cnt[k] + 3'h1 >= thr) && !busy) begin
            next_active[k] = 1'b1;
            next_on_cnt[k] = 3'h0;
          end
        end else begin
          next_off_cnt[k] = raw_detect[k] ? 3'h0 : off_cnt[k] + 3'h1;
          if (!raw_detect[k] && off_cnt[k] + 3'h1 >= tko_pkg::DI_RELEASE) begin
            next_active[k]  = 1'b0;
            next_off_cnt[k] = 3'h0;
          end
        end
      end
      // stuck key: only this key is dropped and recalibrated
      if (active[k] && cfg.timeout != tko_pkg::TKO_TO_NONE
          && cfg.timeout != tko_pkg::TKO_TO_RSVD && ms_tick) begin
        next_stuck_ms[k] = stuck_ms[k] + 16'h0001;
        if (stuck_ms[k] + 16'h0001 >= limit) begin
          next_active[k]  = 1'b0;
          next_recal[k]   = 1'b1;
          next_off_cnt[k] = 3'h0;
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      active    <= '0;
      recal_req <= '0;
      for (int k = 0; k < tko_pkg::NKEYS; k++) begin
        on_cnt[k]   <= '0;
        off_cnt[k]  <= '0;
        stuck_ms[k] <= '0;
      end
    end else begin
      active    <= next_active;
      recal_req <= next_recal;
      for (int k = 0; k < tko_pkg::NKEYS; k++) begin
        on_cnt[k]   <= next_on_cnt[k];
        off_cnt[k]  <= next_off_cnt[k];
        stuck_ms[k] <= next_stuck_ms[k];
      end
    end
  end

  // binary report: first touched key held until it releases
  logic [2:0] rep_idx, next_rep_idx;
  logic       rep_ok, next_rep_ok;
  always_comb begin
    next_rep_idx = rep_idx;
    next_rep_ok  = rep_ok && active[rep_idx];
    if (!next_rep_ok) begin
      for (int k = tko_pkg::NKEYS - 1; k >= 0; k--) begin
        if (active[k]) begin
          next_rep_idx = 3'(k);
          next_rep_ok  = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      rep_idx <= '0;
      rep_ok  <= 1'b0;
    end else begin
      rep_idx <= next_rep_idx;
      rep_ok  <= next_rep_ok;
    end
  end

  // pin encoding; before calibration push-pull pins sit at their idle level
  tko_pkg::tko_pins_t next_pins;
  always_comb begin
    logic [7:0] lvl;
    logic       det;
    lvl = 8'h00;
    det = |active && calib_done;
    if (cfg.binary)
      lvl = {5'h00, rep_ok ? rep_idx : 3'h0};
    else
      lvl = calib_done ? active : 8'h00;
    if (cfg.open_drain) begin
      next_pins.key_out  = 8'h00;
      next_pins.key_oe_n = ~lvl;
      next_pins.det_out  = 1'b0;
      next_pins.det_oe_n = ~det;
    end else begin
      next_pins.key_out  = cfg.act_low ? ~lvl : lvl;
      next_pins.key_oe_n = 8'h00;
      next_pins.det_out  = cfg.act_low ? ~det : det;
      next_pins.det_oe_n = 1'b0;
    end
    if (!sampled) next_pins = '{key_out: 8'h00, key_oe_n: 8'hFF, det_out: 1'b0,
                                det_oe_n: 1'b1};
  end
  always_ff @(posedge mclk) begin
    if (reset) pins <= '{key_out: 8'h00, key_oe_n: 8'hFF, det_out: 1'b0, det_oe_n: 1'b1};
    else       pins <= next_pins;
  end

  // sync / low-power pin watch and burst pair sequencer
  tko_pkg::tko_burst_t bst, next_bst;
  logic        pin_d, next_pin_d, sync_pend, next_sync_pend, woke, next_woke;
  logic        next_lp;
  logic [15:0] hi_cnt, next_hi_cnt;
  logic [8:0]  gap_ms, next_gap_ms, quiet_ms, next_quiet_ms;
  assign burst_req   = (bst != tko_pkg::TKO_IDLE);
  assign burst_group = (bst == tko_pkg::TKO_BURST_B);
  always_comb begin
    logic [8:0] period;
    logic       go, hi_full, any;
    period  = 9'h000;
    go      = 1'b0;
    any     = |active;
    hi_full = (hi_cnt == 16'(LP_PULSE_CYCLES));
    next_pin_d  = sync_or_lowpower_pin;
    next_hi_cnt = !sync_or_lowpower_pin ? 16'h0000 : hi_full ? hi_cnt : hi_cnt + 16'h0001;
    next_quiet_ms = (sync_or_lowpower_pin != pin_d) ? 9'h000 :
                    (ms_tick && quiet_ms != 9'(tko_pkg::SYNC_QUIET_MS)) ?
                    quiet_ms + 9'h001 : quiet_ms;
    next_sync_pend = sync_pend || (cfg.sync_mode && sync_or_lowpower_pin && !pin_d);
    next_woke = woke;
    next_lp   = low_power_mode;
    if (cfg.sync_mode || !sampled) next_lp = 1'b0;
    else if (any) begin
      next_lp = 1'b0;
      if (low_power_mode) next_woke = 1'b1;
    end else if (next_hi_cnt == 16'(LP_PULSE_CYCLES)) begin
      next_lp   = 1'b1;
      next_woke = 1'b0;
    end
    period = low_power_mode ? cfg.lp_resp_ms :
             woke ? 9'(tko_pkg::WAKE_RESP_MS) : 9'(tko_pkg::NORMAL_RESP_MS);
    if (cfg.sync_mode)
      go = sync_pend || (quiet_ms == 9'(tko_pkg::SYNC_QUIET_MS) && gap_ms >= period);
    else
      go = gap_ms >= period;
    next_gap_ms = (ms_tick && gap_ms != 9'h1FF) ? gap_ms + 9'h001 : gap_ms;
    next_bst = bst;
    case (bst)
      tko_pkg::TKO_IDLE: begin
        if (go && sampled) begin
          next_bst       = tko_pkg::TKO_BURST_A;
          next_gap_ms    = 9'h000;
          // a sync edge landing on the start of a pair is kept for the next pair
          next_sync_pend = cfg.sync_mode && sync_or_lowpower_pin && !pin_d;
        end
      end
      tko_pkg::TKO_BURST_A: if (raw_valid) next_bst = tko_pkg::TKO_BURST_B;
      tko_pkg::TKO_BURST_B: if (raw_valid) next_bst = tko_pkg::TKO_IDLE;
      default: next_bst = tko_pkg::TKO_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      bst <= tko_pkg::TKO_IDLE;
      pin_d <= 1'b0;
      sync_pend <= 1'b0;
      woke <= 1'b0;
      low_power_mode <= 1'b0;
      hi_cnt <= '0;
      gap_ms <= '0;
      quiet_ms <= '0;
    end else begin
      bst <= next_bst;
      pin_d <= next_pin_d;
      sync_pend <= next_sync_pend;
      woke <= next_woke;
      low_power_mode <= next_lp;
      hi_cnt <= next_hi_cnt;
      gap_ms <= next_gap_ms;
      quiet_ms <= next_quiet_ms;
    end
  end

  // checks
  sequence s_burst_a_done;
    bst == tko_pkg::TKO_BURST_A && raw_valid;
  endsequence
  sequence s_burst_b_up;
    ##1 bst == tko_pkg::TKO_BURST_B;
  endsequence
  a_burst_a_then_b: assert property (@(posedge mclk) disable iff (reset)
    s_burst_a_done |-> s_burst_b_up) else $error("burst b did not follow burst a");
  a_cfg_held: assert property (@(posedge mclk) disable iff (reset)
    sampled |=> $stable(cfg)) else $error("strap configuration changed after capture");
  a_quiet_until_cal: assert property (@(posedge mclk) disable iff (reset)
    !calib_done |-> active == 8'h00) else $error("key active before calibration");
  a_bin_upper_low: assert property (@(posedge mclk) disable iff (reset)
    cfg.binary && sampled |=> pins.key_out[7:3] == 5'h00) else $error("upper outputs high");
  a_global_onehot: assert property (@(posedge mclk) disable iff (reset)
    cfg.sup == tko_pkg::TKO_SUP_GLOBAL |-> $onehot0(active)) else $error("two keys in global");
  a_detect_or: assert property (@(posedge mclk) disable iff (reset)
    sampled && !cfg.open_drain && !cfg.act_low |=> pins.det_out == $past(|active && calib_done))
    else $error("detect not the or of keys");
  a_simpl_fixed: assert property (@(posedge mclk) disable iff (reset)
    cfg.simplified |-> !cfg.binary && !cfg.act_low && !cfg.sync_mode
    && cfg.timeout == tko_pkg::TKO_TO_LONG) else $error("simplified settings wrong");
  a_lp_wakes: assert property (@(posedge mclk) disable iff (reset)
    low_power_mode && |active |=> !low_power_mode) else $error("low power kept during touch");
  a_sync_no_lp: assert property (@(posedge mclk) disable iff (reset)
    cfg.sync_mode |=> !low_power_mode) else $error("low power in sync mode");
endmodule // tko_touch_key_ctrl
`default_nettype wire

// file: include/tko_pkg.sv
package tko_pkg;
  // clock and time base
  localparam int CLK_MHZ           = 200;
  localparam int MS_TICK_CYCLES    = 1000 * CLK_MHZ;      // one millisecond of mclk
  localparam int STARTUP_MS        = 350;
  localparam int SYNC_QUIET_MS     = 150;
  localparam int LP_PULSE_US       = 150;
  localparam int LP_PULSE_CYCLES   = LP_PULSE_US * CLK_MHZ; // least width, exact
  localparam int STUCK_SHORT_MS    = 10000;               // 10 seconds
  localparam int STUCK_LONG_MS     = 60000;               // 60 seconds
  localparam int LP_RESP_A_MS      = 110;
  localparam int LP_RESP_B_MS      = 200;
  localparam int LP_RESP_C_MS      = 360;
  localparam int NORMAL_RESP_MS    = 25;
  localparam int WAKE_RESP_MS      = 30;
  // detection integrators
  localparam logic [2:0] DI_NORMAL  = 3'h4;               // plain default for normal detect
  localparam logic [2:0] DI_FAST    = 3'h2;
  localparam logic [2:0] DI_RELEASE = 3'h6;
  localparam int NKEYS = 8;

  typedef enum logic [1:0] {
    TKO_SUP_OFF    = 2'h0,
    TKO_SUP_GROUPS = 2'h1,
    TKO_SUP_GLOBAL = 2'h2
  } tko_sup_t;

  typedef enum logic [1:0] {
    TKO_TO_SHORT = 2'h0,
    TKO_TO_LONG  = 2'h1,
    TKO_TO_NONE  = 2'h2,
    TKO_TO_RSVD  = 2'h3
  } tko_timeout_t;

  // burst pair sequencer, gray along idle -> a -> b
  typedef enum logic [1:0] {
    TKO_IDLE    = 2'h0,
    TKO_BURST_A = 2'h1,
    TKO_BURST_B = 2'h3
  } tko_burst_t;

  typedef struct packed {
    logic         simplified;
    tko_sup_t     sup;
    logic         fast;
    tko_timeout_t timeout;
    logic         binary;
    logic         act_low;
    logic         open_drain;
    logic         sync_mode;
    logic [8:0]   lp_resp_ms;
  } tko_cfg_t;

  typedef struct packed {
    logic [7:0] key_out;
    logic [7:0] key_oe_n;
    logic       det_out;
    logic       det_oe_n;
  } tko_pins_t;
endpackage

// file: testbench/tko_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tko_host_model (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       burst_req,
  input  wire logic       burst_group,
  input  wire logic [7:0] touch,
  input  wire logic [3:0] lag,
  output logic      [7:0] raw_detect,
  output logic            raw_valid,
  output logic      [7:0] order_errs
);
  logic [3:0] wait_cnt;
  logic       last_group;

  initial begin
    raw_detect = 8'h00;
    raw_valid  = 1'b0;
    order_errs = 8'h00;
    wait_cnt   = 4'h0;
    last_group = 1'b1;
  end

  // front end answers each burst after lag cycles; idle data toggles so stale values never pass
  always @(posedge mclk) begin
    if (reset) begin
      raw_valid  <= 1'b0;
      wait_cnt   <= 4'h0;
      last_group <= 1'b1;
    end else if (burst_req && !raw_valid && wait_cnt >= lag) begin
      raw_valid  <= 1'b1;
      raw_detect <= touch;
      wait_cnt   <= 4'h0;
      last_group <= burst_group;
      if (burst_group == last_group) order_errs <= order_errs + 8'h01;
    end else begin
      raw_valid  <= 1'b0;
      raw_detect <= ~raw_detect;
      if (burst_req && !raw_valid) wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // tko_host_model
`default_nettype wire

// file: testbench/tko_touch_key_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tko_touch_key_ctrl_bench;
  localparam int MS = 20;
  logic               mclk, reset, pin, bin, al, od;
  logic               raw_valid, burst_req, burst_group, calib_done, low_power_mode;
  logic [8:0]         straps;
  logic [7:0]         touch, raw_detect, recal_req, errs;
  logic [3:0]         lag;
  tko_pkg::tko_pins_t pins;
  int                 failures, check_count;

  tko_touch_key_ctrl #(.MS_TICK_CYCLES(MS), .LP_PULSE_CYCLES(10)) DUT (
    .mclk(mclk), .reset(reset),
    .suppress_strap_lo(straps[6]), .suppress_strap_hi(straps[7]),
    .stuck_timeout_strap_lo(straps[4]), .stuck_timeout_strap_hi(straps[5]),
    .output_format_strap(straps[3]), .output_polarity_strap(straps[2]),
    .sync_lowpower_strap_lo(straps[0]), .sync_lowpower_strap_hi(straps[1]),
    .simplified_mode_strap(straps[8]), .sync_or_lowpower_pin(pin),
    .raw_detect(raw_detect), .raw_valid(raw_valid), .burst_req(burst_req),
    .burst_group(burst_group), .pins(pins), .recal_req(recal_req),
    .calib_done(calib_done), .low_power_mode(low_power_mode));

  tko_host_model host (
    .mclk(mclk), .reset(reset), .burst_req(burst_req), .burst_group(burst_group),
    .touch(touch), .lag(lag), .raw_detect(raw_detect), .raw_valid(raw_valid),
    .order_errs(errs));

  // free-running 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // expected pins for a set of confirmed keys, in the current output mode
  function automatic tko_pkg::tko_pins_t exp_pins(input logic [7:0] m, input logic [2:0] c);
    tko_pkg::tko_pins_t e;
    e.key_out  = m;
    e.key_oe_n = 8'h00;
    e.det_out  = |m;
    e.det_oe_n = 1'b0;
    if (bin) begin
      e.key_out = {5'h00, c};
    end else if (od) begin
      e.key_out  = 8'h00;
      e.key_oe_n = ~m;
      e.det_out  = 1'b0;
      e.det_oe_n = ~|m;
    end else if (al) begin
      e.key_out = ~m;
      e.det_out = ~|m;
    end
    return e;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pins(input logic [7:0] m, input logic [2:0] c);
    chk({14'h0, pins}, {14'h0, exp_pins(m, c)});
  endtask

  // inputs move 1 ns after the edge so the design never sees a race
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic sync_pulse(input int n);
    repeat (n) begin
      tick(1);
      pin = 1'b1;
      tick(2);
      pin = 1'b0;
      tick(40);
    end
  endtask

  // bounded wait for the detect line; a timeout shows up as a mismatch
  task automatic wait_det(input logic v);
    int n;
    n = 0;
    while (pins.det_out !== (v ^ al) && n < 9000) begin
      tick(1);
      n++;
    end
    chk({31'h0, pins.det_out}, {31'h0, v ^ al});
  endtask

  task automatic do_reset(input logic [8:0] s, input logic b, input logic a, input logic o);
    int n;
    straps = s;
    bin = b;
    al = a;
    od = o;
    touch = 8'h00;
    pin = 1'b0;
    tick(1);
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(3);
    check_pins(8'h00, 3'h0);
    n = 3;
    while (calib_done !== 1'b1 && n < 8000) begin
      tick(1);
      n++;
    end
    chk({31'h0, n >= tko_pkg::STARTUP_MS * MS - 1 && n <= tko_pkg::STARTUP_MS * MS + 1}, 1);
    sync_pulse(1);
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of about 65k cycles
  initial begin
    #500000;
    failures++;
    $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
    conclude();
  end

  // main sequence, one reset per strap setting since straps are read only once
  initial begin
    reset = 1'b1;
    pin = 1'b0;
    touch = 8'h00;
    lag = 4'h1;
    straps = 9'h000;
    bin = 1'b0;
    al = 1'b0;
    od = 1'b0;
    failures = 0;
    check_count = 0;
    do_reset(9'h008, 1'b0, 1'b0, 1'b0);
    touch = 8'h42;
    sync_pulse(3);
    check_pins(8'h00, 3'h0);
    sync_pulse(1);
    check_pins(8'h42, 3'h0);
    straps = 9'h000;
    touch = 8'h00;
    sync_pulse(5);
    check_pins(8'h42, 3'h0);
    sync_pulse(1);
    check_pins(8'h00, 3'h0);
    $display("test direct finished");
    lag = 4'h6;
    do_reset(9'h000, 1'b1, 1'b0, 1'b0);
    touch = 8'h20;
    sync_pulse(4);
    check_pins(8'h20, 3'h5);
    tick(1);
    check_pins(8'h20, 3'h5);
    touch = 8'h24;
    sync_pulse(4);
    check_pins(8'h24, 3'h5);
    touch = 8'h04;
    sync_pulse(6);
    check_pins(8'h04, 3'h2);
    // no more sync pulses: bursts must free-run to see the release
    touch = 8'h00;
    wait_det(1'b0);
    tick(2);
    check_pins(8'h00, 3'h0);
    $display("test binary finished");
    lag = 4'h1;
    do_reset(9'h044, 1'b0, 1'b0, 1'b1);
    touch = 8'h08;
    sync_pulse(1);
    check_pins(8'h00, 3'h0);
    sync_pulse(1);
    check_pins(8'h08, 3'h0);
    do_reset(9'h0cc, 1'b0, 1'b1, 1'b0);
    touch = 8'h11;
    sync_pulse(4);
    check_pins(8'h01, 3'h0);
    do_reset(9'h088, 1'b0, 1'b0, 1'b0);
    touch = 8'h15;
    sync_pulse(4);
    check_pins(8'h05, 3'h0);
    $display("test formats finished");
    do_reset(9'h049, 1'b0, 1'b0, 1'b0);
    chk({31'h0, low_power_mode}, 0);
    pin = 1'b1;
    tick(12);
    pin = 1'b0;
    tick(3);
    chk({31'h0, low_power_mode}, 1);
    touch = 8'h80;
    wait_det(1'b1);
    chk({31'h0, low_power_mode}, 0);
    check_pins(8'h80, 3'h0);
    pin = 1'b1;
    touch = 8'h00;
    wait_det(1'b0);
    tick(5);
    chk({31'h0, low_power_mode}, 1);
    $display("test low power finished");
    do_reset(9'h100, 1'b0, 1'b0, 1'b0);
    touch = 8'h24;
    wait_det(1'b1);
    tick(8);
    check_pins(8'h24, 3'h0);
    $display("test simplified finished");
    chk({24'h0, recal_req}, 0);
    chk({24'h0, errs}, 0);
    conclude();
  end
endmodule // tko_touch_key_ctrl_bench
`default_nettype wire
